// [core/tpm_pkg.sv]
// Shared constants of the test pattern and mirror pixel path.
// Assumes a monochrome pixel stream of at most ten bits per pixel.
package tpm_pkg;

  // Pixel word, pattern selection, flag and buffered word widths
  localparam int unsigned PIX_W     = 10;
  localparam int unsigned PAT_W     = 3;
  localparam int unsigned FLAG_W    = 3;
  localparam int unsigned FIFO_W    = PIX_W + FLAG_W;

  // Pattern selection codes
  localparam logic [PAT_W-1:0] PAT_SENSOR = 3'h0;
  localparam logic [PAT_W-1:0] PAT_HRAMP  = 3'h1;
  localparam logic [PAT_W-1:0] PAT_VRAMP  = 3'h2;
  localparam logic [PAT_W-1:0] PAT_DIAG   = 3'h3;
  localparam logic [PAT_W-1:0] PAT_PURITY = 3'h4;

  // Mirror selection codes
  localparam logic MIR_NORMAL = 1'b0;
  localparam logic MIR_HFLIP  = 1'b1;

  // Grey value ceilings for the two pixel depths
  localparam logic [PIX_W-1:0] MAX_8BIT  = 10'h0FF;
  localparam logic [PIX_W-1:0] MAX_10BIT = 10'h3FF;

  // Flag positions inside a buffered word, pixel in the low bits
  localparam int unsigned FL_EOL = PIX_W;
  localparam int unsigned FL_SOL = PIX_W + 1;
  localparam int unsigned FL_SOF = PIX_W + 2;

  // Default line buffer size and output buffer depth
  localparam int unsigned LINE_MAX_DEF = 2048;
  localparam int unsigned FIFO_DEPTH   = 4;

endpackage : tpm_pkg

// [core/tpm_fifo.sv]
// Small shift-register FIFO with valid and ready on both sides.
// Head word and status are flip-flops so a top level may route them out directly.
`timescale 1ns/1ps
module tpm_fifo #(
  parameter int unsigned WIDTH = 13,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  logic [WIDTH-1:0] dat_ff [DEPTH];
  logic [DEPTH-1:0] vld_ff;
  logic [WIDTH-1:0] nxt_dat [DEPTH];
  logic [DEPTH-1:0] nxt_vld;
  logic [DEPTH-1:0] vld_s;
  logic             push;
  logic             pop;

  assign pop       = vld_ff[0] & out_ready;
  assign push      = in_valid & ~vld_ff[DEPTH-1];
  assign in_ready  = ~vld_ff[DEPTH-1];  // Full only when the last slot is used
  assign out_valid = vld_ff[0];
  assign out_data  = dat_ff[0];

  // One slot per entry; a pop shifts everything toward the head
  for (genvar i = 0; i < DEPTH; i++) begin : g_slot
    logic             up_vld;
    logic [WIDTH-1:0] up_dat;
    logic             tgt;
    if (i == DEPTH - 1) begin : g_top
      assign up_vld = 1'b0;
      assign up_dat = '0;
    end else begin : g_mid
      assign up_vld = vld_ff[i+1];
      assign up_dat = dat_ff[i+1];
    end
    assign vld_s[i] = pop ? up_vld : vld_ff[i];
    if (i == 0) begin : g_t0
      assign tgt = ~vld_s[0];
    end else begin : g_tn
      assign tgt = vld_s[i-1] & ~vld_s[i];
    end

    // Incoming word lands in the lowest empty slot after the shift
    always_comb begin
      nxt_vld[i] = vld_s[i];
      nxt_dat[i] = pop ? up_dat : dat_ff[i];
      if (push && tgt) begin
        nxt_vld[i] = 1'b1;
        nxt_dat[i] = in_data;
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        vld_ff[i] <= 1'b0;
        dat_ff[i] <= '0;
      end else begin
        vld_ff[i] <= nxt_vld[i];
        dat_ff[i] <= nxt_dat[i];
      end
    end
  end

endmodule // tpm_fifo

// [core/tpm_top.sv]
// Test pattern insertion and horizontal line mirror for the camera pixel path.
// Assumes sensor pixels arrive with line and frame markers and can be held off by in_ready.
// Contract
// - Mirror select 0 keeps line order, 1 reverses every line horizontally, an overlong line per bank-sized chunk.
// - Mirroring in hardware with ping-pong line banks, no frame rate loss.
// - Pattern pixels replace sensor pixels before downstream lookup table.
// - Horizontal ramp rises by one per pixel, wraps, restarts at zero each line.
// - Vertical ramp rises by one per line, wraps, across the frame.
// - Diagonal ramp sums both ramps, first pixel advances one per frame.
// - Purity gives all frame pixels one value, rising one per frame, wrapping.
// - Pattern select 0 sensor, 1 horizontal, 2 vertical, 3 diagonal, 4 purity.
// - Pixel depth of 8 or 10 bits sets the pattern wrap value.
`timescale 1ns/1ps
module tpm_top
  import tpm_pkg::*;
#(
  parameter int unsigned LINE_MAX = tpm_pkg::LINE_MAX_DEF,
  parameter int unsigned AW       = $clog2(LINE_MAX)
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic [tpm_pkg::PAT_W-1:0] pattern_select,
  input  wire logic                      mirror_select,
  input  wire logic                      pix_10bit,
  input  wire logic                      in_valid,
  output logic                           in_ready,
  input  wire logic [tpm_pkg::PIX_W-1:0] in_data,
  input  wire logic                      in_sof,
  input  wire logic                      in_sol,
  input  wire logic                      in_eol,
  output logic                           out_valid,
  input  wire logic                      out_ready,
  output logic [tpm_pkg::PIX_W-1:0]      out_data,
  output logic                           out_sof,
  output logic                           out_sol,
  output logic                           out_eol
);
  import tpm_pkg::*;

  localparam logic [AW-1:0] COL_LAST = AW'(LINE_MAX - 1);

  // Writer side state
  logic                 in_ready_ff, nxt_in_ready;
  logic                 wb_ff, nxt_wb;
  logic [AW-1:0]        col_ff, nxt_col;
  logic [PIX_W-1:0]     line_ff, nxt_line;
  logic [PIX_W-1:0]     frm_ff, nxt_frm;
  logic [PAT_W-1:0]     pat_ff, nxt_pat;
  logic                 mir_ff, nxt_mir;
  logic                 lsof_ff, nxt_lsof;
  logic [1:0]           busy_ff, nxt_busy;
  logic [AW-1:0]        len_ff [2];
  logic [AW-1:0]        nxt_len [2];
  logic [1:0]           tsof_ff, nxt_tsof;
  logic [1:0]           tmir_ff, nxt_tmir;

  // Reader side state
  logic                 rb_ff, nxt_rb;
  logic [AW-1:0]        idx_ff, nxt_idx;
  logic                 rv_ff, nxt_rv;
  logic [FLAG_W-1:0]    rfl_ff, nxt_rfl;
  logic [PIX_W-1:0]     rdat_ff;

  // Line banks, two lines deep
  logic [PIX_W-1:0]     mem [2*LINE_MAX];

  logic                 acc;
  logic [AW-1:0]        cur_col;
  logic [PIX_W-1:0]     cur_line;
  logic [PIX_W-1:0]     cur_frm;
  logic [PAT_W-1:0]     cur_pat;
  logic                 cur_mir;
  logic                 cur_lsof;
  logic                 line_end;
  logic [PIX_W-1:0]     pmax;
  logic [PIX_W-1:0]     gen_pix;
  logic [PIX_W-1:0]     wr_pix;
  logic                 issue;
  logic                 rd_last;
  logic [AW-1:0]        rd_addr;
  logic                 fifo_rdy;
  logic [FIFO_W-1:0]    fifo_out;

  assign acc = in_valid & in_ready_ff;

  // Per-pixel position and the frame's settings, sampled at the frame's first pixel
  always_comb begin
    cur_col  = in_sol ? '0 : col_ff;
    cur_line = in_sof ? '0 : (in_sol ? line_ff + 10'h001 : line_ff);
    cur_frm  = in_sof ? frm_ff + 10'h001 : frm_ff;
    cur_pat  = in_sof ? pattern_select : pat_ff;
    cur_mir  = in_sof ? mirror_select : mir_ff;
    cur_lsof = in_sol ? in_sof : lsof_ff;
    line_end = in_eol | (cur_col == COL_LAST);    // Overlong lines are cut at the bank size
  end

  // Pattern generator; masking with the depth ceiling gives the wrap
  always_comb begin
    pmax = pix_10bit ? MAX_10BIT : MAX_8BIT;
    unique case (cur_pat)
      PAT_HRAMP:  gen_pix = PIX_W'(cur_col);
      PAT_VRAMP:  gen_pix = cur_line;
      PAT_DIAG:   gen_pix = PIX_W'(cur_col) + cur_line + cur_frm;
      PAT_PURITY: gen_pix = cur_frm;
      default:    gen_pix = in_data;          // Sensor video, also unused codes
    endcase
    wr_pix = gen_pix & pmax;
  end

  // Writer: fills bank wb, hands it to the reader at line end
  always_comb begin
    nxt_wb   = wb_ff;
    nxt_col  = col_ff;
    nxt_line = line_ff;
    nxt_frm  = frm_ff;
    nxt_pat  = pat_ff;
    nxt_mir  = mir_ff;
    nxt_lsof = lsof_ff;
    nxt_len  = len_ff;
    nxt_tsof = tsof_ff;
    nxt_tmir = tmir_ff;
    nxt_busy = busy_ff;
    if (issue && rd_last) begin
      nxt_busy[rb_ff] = 1'b0;
    end
    if (acc) begin
      nxt_col  = cur_col + AW'(1);
      nxt_line = cur_line;
      nxt_frm  = cur_frm;
      nxt_pat  = cur_pat;
      nxt_mir  = cur_mir;
      nxt_lsof = cur_lsof;
      if (line_end) begin
        nxt_busy[wb_ff] = 1'b1;      // Writer only fills a free bank, so no clash with the clear
        nxt_len[wb_ff]  = cur_col;
        nxt_tsof[wb_ff] = cur_lsof;
        nxt_tmir[wb_ff] = cur_mir;
        nxt_wb          = ~wb_ff;
        nxt_col         = '0;
        nxt_lsof        = 1'b0;      // A cut line's second chunk must not repeat the frame start
      end
    end
    nxt_in_ready = ~nxt_busy[nxt_wb];  // Stall the sensor only if both banks are full
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      in_ready_ff <= 1'b0;
      wb_ff       <= 1'b0;
      col_ff      <= '0;
      line_ff     <= '0;
      frm_ff      <= MAX_10BIT;  // First frame then shows value zero
      pat_ff      <= PAT_SENSOR;
      mir_ff      <= MIR_NORMAL;
      lsof_ff     <= 1'b0;
      busy_ff     <= 2'h0;
      len_ff      <= '{default: '0};
      tsof_ff     <= 2'h0;
      tmir_ff     <= 2'h0;
    end else begin
      in_ready_ff <= nxt_in_ready;
      wb_ff       <= nxt_wb;
      col_ff      <= nxt_col;
      line_ff     <= nxt_line;
      frm_ff      <= nxt_frm;
      pat_ff      <= nxt_pat;
      mir_ff      <= nxt_mir;
      lsof_ff     <= nxt_lsof;
      busy_ff     <= nxt_busy;
      len_ff      <= nxt_len;
      tsof_ff     <= nxt_tsof;
      tmir_ff     <= nxt_tmir;
    end
  end

  // Bank memory: write port from the writer, registered read for the reader
  always_ff @(posedge clk) begin
    if (acc) begin
      mem[{wb_ff, cur_col}] <= wr_pix;
    end
    if (issue) begin
      rdat_ff <= mem[{rb_ff, rd_addr}];
    end
  end

  // Reader: walks a full bank forward or backward; one stage of hold before the FIFO
  always_comb begin
    issue   = busy_ff[rb_ff] & (~rv_ff | fifo_rdy);
    rd_last = (idx_ff == len_ff[rb_ff]);
    rd_addr = (tmir_ff[rb_ff] == MIR_HFLIP) ? len_ff[rb_ff] - idx_ff : idx_ff;
    nxt_rb  = rb_ff;
    nxt_idx = idx_ff;
    nxt_rfl = rfl_ff;
    nxt_rv  = rv_ff & ~fifo_rdy;
    if (issue) begin
      nxt_rv  = 1'b1;
      nxt_rfl = {tsof_ff[rb_ff] & (idx_ff == '0), idx_ff == '0, rd_last};
      nxt_idx = rd_last ? '0 : idx_ff + AW'(1);
      nxt_rb  = rd_last ? ~rb_ff : rb_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rb_ff  <= 1'b0;
      idx_ff <= '0;
      rv_ff  <= 1'b0;
      rfl_ff <= '0;
    end else begin
      rb_ff  <= nxt_rb;
      idx_ff <= nxt_idx;
      rv_ff  <= nxt_rv;
      rfl_ff <= nxt_rfl;
    end
  end

  // Output buffer absorbs downstream stalls; its head is a flip-flop
  tpm_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (rv_ff),
    .in_ready  (fifo_rdy),
    .in_data   ({rfl_ff, rdat_ff}),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (fifo_out)
  );

  assign in_ready = in_ready_ff;
  assign out_data = fifo_out[PIX_W-1:0];
  assign out_sof  = fifo_out[FL_SOF];
  assign out_sol  = fifo_out[FL_SOL];
  assign out_eol  = fifo_out[FL_EOL];

endmodule // tpm_top

// [tb/tpm_top_assertions.sv]
// Port checker for tpm_top, attached by bind.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module tpm_top_assertions
  import tpm_pkg::*;
#(
  parameter int unsigned LINE_MAX = 2048,
  parameter int unsigned AW       = 11
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic [PAT_W-1:0]  pattern_select,
  input wire logic              mirror_select,
  input wire logic              pix_10bit,
  input wire logic              in_valid,
  input wire logic              in_ready,
  input wire logic [PIX_W-1:0]  in_data,
  input wire logic              in_sof,
  input wire logic              in_sol,
  input wire logic              in_eol,
  input wire logic              out_valid,
  input wire logic              out_ready,
  input wire logic [PIX_W-1:0]  out_data,
  input wire logic              out_sof,
  input wire logic              out_sol,
  input wire logic              out_eol
);
  logic        eol_seen_ff;
  logic [15:0] ocnt_ff;
  logic [15:0] bal_ff;
  wire         in_take  = in_valid && in_ready;
  wire         out_take = out_valid && out_ready;

  // Output line position and words owed, so flags tie back to their cause
  always_ff @(posedge clk) begin
    if (rst) begin
      eol_seen_ff <= 1'b1;
      ocnt_ff     <= 16'h0;
      bal_ff      <= 16'h0;
    end else begin
      if (out_take) eol_seen_ff <= out_eol;
      if (out_take) ocnt_ff <= out_eol ? 16'h0 : ocnt_ff + 16'h1;
      bal_ff <= bal_ff + 16'(in_take) - 16'(out_take);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_reset_quiet: assert property (disable iff (1'b0) rst |=> !out_valid && !in_ready)
    else $error("outputs active after reset");
  a_ready_after_reset: assert property ($fell(rst) |=> in_ready)
    else $error("input not ready after reset");
  a_out_hold_stable: assert property (out_valid && !out_ready |=>
    out_valid && $stable({out_data, out_sof, out_sol, out_eol})) else $error("word changed while stalled");
  a_sol_after_eol: assert property (out_valid |-> out_sol == eol_seen_ff)
    else $error("line start flag out of place");
  a_sof_with_sol: assert property (out_valid && out_sof |-> out_sol)
    else $error("frame start without line start");
  a_line_bound: assert property (out_valid |-> ocnt_ff < LINE_MAX)
    else $error("output line too long");
  a_depth_mask: assert property (out_valid && !pix_10bit |-> out_data[9:8] == 2'h0)
    else $error("pixel above eight bit range");
  a_out_needs_in: assert property (out_valid |-> bal_ff != 16'h0)
    else $error("word out without word in");

  c_refused: cover property (in_valid && !in_ready);
  c_stalled: cover property (out_valid && !out_ready);
  c_frame_out: cover property (out_take && out_sof);
endmodule // tpm_top_assertions

bind tpm_top tpm_top_assertions #(.LINE_MAX(LINE_MAX), .AW(AW)) u_chk (.clk(clk), .rst(rst),
  .pattern_select(pattern_select), .mirror_select(mirror_select), .pix_10bit(pix_10bit),
  .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data), .in_sof(in_sof), .in_sol(in_sol),
  .in_eol(in_eol), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
  .out_sof(out_sof), .out_sol(out_sol), .out_eol(out_eol));

// [tb/tpm_sink.sv]
// Downstream partner: takes words with random back-pressure.
// Assumes the block's clk and rst; stall forces ready low.
`timescale 1ns/1ps
module tpm_sink (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic stall,
  output logic      ready_ff
);
  // Random ready so the output buffer both fills and drains
  always_ff @(posedge clk) ready_ff <= !rst && !stall && ($urandom % 4 != 0);
endmodule // tpm_sink

// [tb/tpm_top_tb.sv]
// Bench for tpm_top: frames of every pattern code against a queue model.
// Assumes tpm_sink downstream and a short line buffer for speed.
`timescale 1ns/1ps
module tpm_top_tb;
  import tpm_pkg::*;
  localparam int W = 5;
  localparam int H = 3;
  localparam int LM = 16;
  logic clk, rst, in_valid, in_sof, in_sol, in_eol, mirror_select, pix_10bit, stall;
  logic refused = 1'b0;
  logic in_ready, out_valid, out_ready, out_sof, out_sol, out_eol;
  logic [PAT_W-1:0] pattern_select;
  logic [PIX_W-1:0] in_data, out_data;
  int num_errors = 0;
  int checks_done = 0;
  int fr = 0;
  logic [12:0] exp_q[$];

  tpm_top #(.LINE_MAX(LM)) dut (.clk(clk), .rst(rst), .pattern_select(pattern_select),
    .mirror_select(mirror_select), .pix_10bit(pix_10bit), .in_valid(in_valid), .in_ready(in_ready),
    .in_data(in_data), .in_sof(in_sof), .in_sol(in_sol), .in_eol(in_eol), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data), .out_sof(out_sof), .out_sol(out_sol), .out_eol(out_eol));
  tpm_sink u_sink (.clk(clk), .rst(rst), .stall(stall), .ready_ff(out_ready));

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  task automatic fail(string s);
    num_errors++;
    $display("unexpected at %0t: %s", $time, s);
  endtask

  task automatic results;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Model pixel: column, line and frame counts masked to the pixel depth
  function automatic logic [9:0] gen(int p, int c, int l, logic [9:0] d, logic b);
    int v;
    case (p)
      1: v = c;
      2: v = l;
      3: v = c + l + fr;
      4: v = fr;
      default: v = d;
    endcase
    return b ? v[9:0] : {2'h0, v[7:0]};
  endfunction

  // One frame; settings are scrambled on every pixel but the first of the frame
  // Lines longer than the bank come back as chunks of at most LM words, column restarting
  task automatic frame(int p, logic m, logic b, int w);
    logic [9:0] d;
    logic [9:0] ld[$];
    pix_10bit <= b;
    for (int l = 0; l < H; l++) begin
      ld.delete();
      for (int c = 0; c < w; c++) begin
        d = $urandom;
        if ($urandom % 4 == 0) begin
          in_valid <= 0;
          @(posedge clk);
        end
        in_valid <= 1;
        in_data <= d;
        in_sof <= c == 0 && l == 0;
        in_sol <= c == 0;
        in_eol <= c == w - 1;
        pattern_select <= (c == 0 && l == 0) ? PAT_W'(p) : PAT_W'($urandom);
        mirror_select <= (c == 0 && l == 0) ? m : 1'($urandom);
        if (m) ld.push_front(gen(p, c % LM, l, d, b));
        else ld.push_back(gen(p, c % LM, l, d, b));
        do @(posedge clk); while (in_ready !== 1'b1);
        if (c % LM == LM - 1 || c == w - 1) begin
          foreach (ld[k]) exp_q.push_back({k == 0 && l == 0 && c < LM, k == 0, k == ld.size() - 1, ld[k]});
          ld.delete();
        end
      end
    end
    in_valid <= 0;
    fr++;
  endtask

  // Every word taken downstream is compared with the model
  always @(posedge clk) begin
    if (!rst && in_valid && in_ready === 1'b0) refused <= 1;
    if (!rst && out_valid === 1'b1 && out_ready) begin
      checks_done++;
      if (exp_q.size() == 0 || {out_sof, out_sol, out_eol, out_data} !== exp_q[0]) fail("output word");
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end

  initial begin
    rst = 1; in_valid = 0; in_data = 0; in_sof = 0; in_sol = 0; in_eol = 0;
    pattern_select = 0; mirror_select = 0; pix_10bit = 1; stall = 0;
    void'($urandom(8251));
    repeat (3) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 12; i++) begin
      if (i == 4) fork
        begin
          stall <= 1;
          repeat (30) @(posedge clk);
          stall <= 0;
        end
      join_none
      frame(i % 6, 1'((i / 6 + i) % 2), i < 6, i >= 9 ? 20 : W);
      repeat (300) if (exp_q.size() != 0) @(posedge clk);
      if (exp_q.size() != 0) fail("words missing");
    end
    if (refused !== 1'b1) fail("input never held off");
    results();
  end

  // Watchdog well beyond the few hundred cycles the frames need
  initial begin
    #500000;
    fail("timeout");
    results();
  end
endmodule // tpm_top_tb
